// *** rtl/sfrb_pkg.sv ***
/*
 * sfrb_pkg: offsets, field positions, reset values and masks of the upper
 * bank 0 and lower bank 1 special function register window.
 * assumes: byte registers, one per aligned 32-bit apb word.
 */
package sfrb_pkg;
    // ****************************************************************
    // bus geometry
    // ****************************************************************
    localparam int unsigned ADDR_W = 12;         // byte address bits used
    localparam int unsigned BANK_W = 2;          // bank select bits
    localparam int unsigned LOC_W  = 7;          // in-bank location bits

    // ****************************************************************
    // locations, printed offset = bank*0x80 + location; byte addr = 4x
    // ****************************************************************
    localparam logic [8:0] OFS_CCP1_HIGH  = 9'h016; // capture_compare1_high
    localparam logic [8:0] OFS_CCP1_CTRL  = 9'h017; // capture_compare1_control
    localparam logic [8:0] OFS_RX_STATUS  = 9'h018; // serial_receive_status_control
    localparam logic [8:0] OFS_TX_DATA    = 9'h019; // serial_transmit_data
    localparam logic [8:0] OFS_RX_DATA    = 9'h01a; // serial_receive_data
    localparam logic [8:0] OFS_CCP2_LOW   = 9'h01b; // capture_compare2_low
    localparam logic [8:0] OFS_CCP2_HIGH  = 9'h01c; // capture_compare2_high
    localparam logic [8:0] OFS_CCP2_CTRL  = 9'h01d; // capture_compare2_control
    localparam logic [8:0] OFS_CONV_HIGH  = 9'h01e; // converter_result_high
    localparam logic [8:0] OFS_CONV_CTRL0 = 9'h01f; // converter_control0
    localparam logic [8:0] OFS_INDIRECT   = 9'h080; // indirect_access_mirror
    localparam logic [8:0] OFS_OPTIONS    = 9'h081; // timer0_and_pullup_options
    localparam logic [8:0] OFS_PC_LOW     = 9'h082; // program_counter_low_mirror
    localparam logic [8:0] OFS_FLAGS      = 9'h083; // cpu_flags_bank_select
    localparam logic [8:0] OFS_POINTER    = 9'h084; // indirect_pointer_mirror
    localparam logic [8:0] OFS_DIR_A      = 9'h085; // port_a_direction
    localparam logic [8:0] OFS_DIR_B      = 9'h086; // port_b_direction
    localparam logic [8:0] OFS_DIR_C      = 9'h087; // port_c_direction
    localparam logic [8:0] OFS_DIR_D      = 9'h088; // port_d_direction
    localparam logic [8:0] OFS_DIR_E      = 9'h089; // port_e_direction_and_slave_port
    localparam logic [8:0] OFS_PC_UPPER   = 9'h08a; // pc_upper_holding_mirror
    localparam logic [8:0] OFS_CORE_IRQ   = 9'h08b; // core_interrupt_control_mirror
    localparam logic [8:0] OFS_PERIPH_IE1 = 9'h08c; // peripheral_interrupt_enable1
    localparam logic [8:0] OFS_PERIPH_IE2 = 9'h08d; // peripheral_interrupt_enable2
    localparam logic [8:0] OFS_RESET_WHY  = 9'h08e; // reset_cause_flags
    localparam logic [8:0] OFS_CYCLES     = 9'h08f; // unimplemented hole

    // ****************************************************************
    // implemented-bit masks
    // ****************************************************************
    localparam logic [7:0] MSK_CCP_CTRL  = 8'h3f;
    localparam logic [7:0] MSK_DIR_A_28  = 8'h1f; // bit 5 absent on small part
    localparam logic [7:0] MSK_DIR_A_40  = 8'h3f;
    localparam logic [7:0] MSK_DIR_E     = 8'hf7;
    localparam logic [7:0] MSK_DIR_E_WR  = 8'h17; // ibf/obf/ibov are status
    localparam logic [7:0] MSK_PC_UPPER  = 8'h1f;
    localparam logic [7:0] MSK_IE1_28    = 8'h7f; // slave port enable absent
    localparam logic [7:0] MSK_IE1_40    = 8'hff;
    localparam logic [7:0] MSK_IE2       = 8'h89;
    localparam logic [7:0] MSK_RESET_WHY = 8'h03;
    localparam logic [7:0] MSK_RX_WR     = 8'hf8; // errors and ninth bit are status
    localparam logic [7:0] MSK_FLAGS_WR  = 8'he7; // timeout/powerdown are status

    // ****************************************************************
    // reset values, power-on and other resets
    // ****************************************************************
    localparam logic [7:0] RST_ZERO      = 8'h00;
    localparam logic [7:0] RST_OPTIONS   = 8'hff;
    localparam logic [7:0] RST_DIR_A     = 8'h3f;
    localparam logic [7:0] RST_DIR_FULL  = 8'hff;
    localparam logic [7:0] RST_DIR_E     = 8'h07;
    localparam logic [7:0] RST_FLAGS_POR = 8'h18; // timeout and powerdown set
    localparam logic [7:0] RST_WHY_POR   = 8'h00; // both cause bits low

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int unsigned FLAGS_BANK_LSB = 5;  // rp1:rp0 at 6:5
    localparam int unsigned FLAGS_TO       = 4;
    localparam int unsigned FLAGS_PD       = 3;
    localparam int unsigned WHY_POR        = 1;
    localparam int unsigned WHY_BOR        = 0;
    localparam int unsigned CONV_GO        = 2;
endpackage : sfrb_pkg

// *** rtl/sfrb_bank.sv ***
/*
 * sfrb_bank: register window of the cpu special function map (upper bank 0,
 * bank 1 to 8Eh) reached over apb. apb byte address = 4 x register offset.
 * assumes: pclk 50 MHz; reset causes and peripheral status arrive as
 * synchronous inputs; peripherals behind the registers live elsewhere.
 */
// The APB register port was chosen for this implementation.
// Function
// RL1 - unimplemented locations and bits read zero, ignore writes
// RL2 - five-bit holding register feeds counter upper bits
// RL3 - core registers mirrored into every bank
// RL4 - small package: extra port registers read zero
// RL5 - software keeps slave port irq bits clear
// RL6 - power-on and other resets load different values
// RL7 - byte registers decoded from bank and location
`timescale 1ns/10ps
module sfrb_bank
    import sfrb_pkg::*;
(
    // apb slave
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // device reset causes, one-cycle pulses, then the package select level
    input  wire logic              power_on_reset,
    input  wire logic              brown_out_reset,
    input  wire logic              external_master_clear,
    input  wire logic              watchdog_reset,
    input  wire logic              small_package,
    // status from the core and peripherals
    input  wire logic [7:0]        rx_data_in,
    input  wire logic              rx_data_load,
    input  wire logic [2:0]        rx_status_in,
    input  wire logic [2:0]        slave_port_status,
    input  wire logic [7:0]        indirect_data,
    input  wire logic              pc_load,
    input  wire logic [7:0]        pc_low_in,
    // core-facing outputs
    output logic [12:0]            program_counter,
    output logic [1:0]             bank_select,
    output logic [7:0]             indirect_pointer,
    output logic [7:0]             core_interrupt_control,
    output logic                   indirect_write,
    output logic [7:0]             indirect_wdata,
    output logic [7:0]             tx_data_out,
    output logic                   tx_data_load
);
    // ****************************************************************
    // decode
    // ****************************************************************
    logic [8:0] offset;          // printed offset from byte address
    logic [1:0] bank;            // bank select bits of the offset
    logic [6:0] loc;             // in-bank location
    logic       wr_en;           // write takes effect this edge
    logic       rd_en;           // read data sampled this edge
    logic [7:0] wbyte;           // write byte
    logic       warm_rst;        // master clear or watchdog
    logic       cold_rst;        // power-on or brown-out

    // word index; above the window only the core mirrors in banks 2 and 3 answer, the rest reads zero
    assign offset   = paddr[10:2];
    assign bank     = offset[8:7];
    assign loc      = offset[6:0];
    assign wbyte    = pwdata[7:0];
    assign wr_en    = psel & penable & pwrite;
    assign rd_en    = psel & penable & ~pwrite;
    assign cold_rst = power_on_reset | brown_out_reset;
    assign warm_rst = external_master_clear | watchdog_reset;
    assign pready   = 1'b1;      // zero wait states
    assign pslverr  = 1'b0;      // holes answer zero, not an error

    // true when the access hits a location of the window
    function automatic logic hit(input logic [8:0] ofs, input logic [8:0] tgt);
        hit = (ofs == tgt) && (paddr[ADDR_W-1] == 1'b0);
    endfunction : hit

    // mirrored core location: same register from every bank
    function automatic logic core_hit(input logic [6:0] l, input logic [6:0] tgt);
        core_hit = (l == tgt) && (paddr[ADDR_W-1] == 1'b0);
    endfunction : core_hit

    // ****************************************************************
    // storage
    // ****************************************************************
    logic [7:0] ccp1_high, ccp1_ctrl, rx_ctrl, tx_data, rx_data;
    logic [7:0] ccp2_low, ccp2_high, ccp2_ctrl, conv_high, conv_ctrl0;
    logic [7:0] options, flags, dir_a, dir_b, dir_c, dir_d, dir_e;
    logic [7:0] core_irq, periph_ie1, periph_ie2, reset_why;
    logic [4:0] pc_upper;        // holding register for counter 12:8
    logic [7:0] pc_low;          // counter low byte
    logic [4:0] pc_high;         // counter upper bits, not addressable
    logic [7:0] pointer;         // indirect pointer
    logic [2:0] rx_err;          // receive status bits, hardware owned

    // cold and warm reset load the same set here; the block below keeps contents
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ccp1_ctrl <= RST_ZERO;
            ccp2_ctrl <= RST_ZERO;
            rx_ctrl   <= RST_ZERO;
            tx_data   <= RST_ZERO;
            conv_ctrl0 <= RST_ZERO;
            options   <= RST_OPTIONS;
            dir_a     <= RST_DIR_A;
            dir_b     <= RST_DIR_FULL;
            dir_c     <= RST_DIR_FULL;
            dir_d     <= RST_DIR_FULL;
            dir_e     <= RST_DIR_E;
            periph_ie1 <= RST_ZERO;
            periph_ie2 <= RST_ZERO;
            pc_upper  <= 5'h00;
        end else if (cold_rst || warm_rst) begin
            // same values for both kinds here
            ccp1_ctrl <= RST_ZERO;                     // RL6
            ccp2_ctrl <= RST_ZERO;
            rx_ctrl   <= RST_ZERO;
            tx_data   <= RST_ZERO;
            conv_ctrl0 <= RST_ZERO;
            options   <= RST_OPTIONS;
            dir_a     <= RST_DIR_A;
            dir_b     <= RST_DIR_FULL;
            dir_c     <= RST_DIR_FULL;
            dir_d     <= RST_DIR_FULL;
            dir_e     <= RST_DIR_E;
            periph_ie1 <= RST_ZERO;
            periph_ie2 <= RST_ZERO;
            pc_upper  <= 5'h00;
        end else if (wr_en) begin
            // RL7 RL1: masks drop unimplemented bits
            if (hit(offset, OFS_CCP1_CTRL))  ccp1_ctrl  <= wbyte & MSK_CCP_CTRL;
            if (hit(offset, OFS_CCP2_CTRL))  ccp2_ctrl  <= wbyte & MSK_CCP_CTRL;
            if (hit(offset, OFS_RX_STATUS))  rx_ctrl    <= wbyte & MSK_RX_WR;
            if (hit(offset, OFS_TX_DATA))    tx_data    <= wbyte;
            if (hit(offset, OFS_CONV_CTRL0)) conv_ctrl0 <= wbyte;
            if (hit(offset, OFS_OPTIONS))    options    <= wbyte;
            if (hit(offset, OFS_DIR_A))      dir_a      <= wbyte & MSK_DIR_A_40;
            if (hit(offset, OFS_DIR_B))      dir_b      <= wbyte;
            if (hit(offset, OFS_DIR_C))      dir_c      <= wbyte;
            if (hit(offset, OFS_DIR_D))      dir_d      <= wbyte;
            if (hit(offset, OFS_DIR_E))
                dir_e <= (dir_e & ~MSK_DIR_E_WR) | (wbyte & MSK_DIR_E_WR);
            if (hit(offset, OFS_PERIPH_IE1)) periph_ie1 <= wbyte;
            if (hit(offset, OFS_PERIPH_IE2)) periph_ie2 <= wbyte & MSK_IE2;
            if (core_hit(loc, OFS_PC_UPPER[6:0]))
                pc_upper <= wbyte[4:0];               // RL3 RL2
        end else begin
            dir_e[7:5] <= slave_port_status;         // ibf, obf, ibov from port
        end
    end

    // values undefined at power-on; left unchanged by every reset
    always_ff @(posedge pclk) begin
        if (wr_en && hit(offset, OFS_CCP1_HIGH)) ccp1_high <= wbyte;
        if (wr_en && hit(offset, OFS_CCP2_LOW))  ccp2_low  <= wbyte;
        if (wr_en && hit(offset, OFS_CCP2_HIGH)) ccp2_high <= wbyte;
        if (wr_en && hit(offset, OFS_CONV_HIGH)) conv_high <= wbyte;
        if (wr_en && core_hit(loc, OFS_POINTER[6:0])) pointer <= wbyte; // RL3
    end

    // receive data and error bits: hardware written, zero on any reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data <= RST_ZERO;
            rx_err  <= 3'h0;
        end else if (cold_rst || warm_rst) begin
            rx_data <= RST_ZERO;                       // RL6
            rx_err  <= 3'h0;
        end else if (rx_data_load) begin
            rx_data <= rx_data_in;
            rx_err  <= rx_status_in;
        end
    end

    // ****************************************************************
    // program counter; upper bits only through the holding register
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_low  <= RST_ZERO;
            pc_high <= 5'h00;
        end else if (cold_rst || warm_rst) begin
            pc_low  <= RST_ZERO;
            pc_high <= 5'h00;
        end else if (wr_en && core_hit(loc, OFS_PC_LOW[6:0])) begin
            pc_low  <= wbyte;                         // RL3
            pc_high <= pc_upper;                      // RL2
        end else if (pc_load) begin
            pc_low  <= pc_low_in;
            pc_high <= pc_upper;                      // RL2
        end
    end

    // ****************************************************************
    // flags, interrupt control, reset cause
    // ****************************************************************
    // flags: cold reset 0001 1000, warm keeps low bits and timeout state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= RST_FLAGS_POR;
        end else if (cold_rst) begin
            flags <= RST_FLAGS_POR;                    // RL6
        end else if (warm_rst) begin
            flags <= {3'h0, flags[4:0]};               // RL6
        end else if (wr_en && core_hit(loc, OFS_FLAGS[6:0])) begin
            flags <= (flags & ~MSK_FLAGS_WR) | (wbyte & MSK_FLAGS_WR); // RL3
        end
    end

    // interrupt control: zero except the port-change flag, kept on cold and warm
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_irq <= RST_ZERO;
        end else if (cold_rst || warm_rst) begin
            core_irq <= {7'h00, core_irq[0]};          // RL6
        end else if (wr_en && core_hit(loc, OFS_CORE_IRQ[6:0])) begin
            core_irq <= wbyte;                         // RL3
        end
    end

    // cause bits: cleared by their event, set by software, kept on warm
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_why <= RST_WHY_POR;
        end else if (power_on_reset || brown_out_reset) begin
            reset_why[WHY_POR] <= ~power_on_reset & reset_why[WHY_POR]; // RL6
            reset_why[WHY_BOR] <= ~brown_out_reset & reset_why[WHY_BOR];
        end else if (wr_en && hit(offset, OFS_RESET_WHY)) begin
            reset_why <= wbyte & MSK_RESET_WHY;
        end
    end

    // ****************************************************************
    // read mux
    // ****************************************************************
    logic [7:0] rbyte;           // selected byte
    logic [7:0] rdata_q;         // registered read data

    always_comb begin
        rbyte = 8'h00;                                 // RL1
        if (paddr[ADDR_W-1] == 1'b0) begin
            // core registers answer in every bank
            unique case (loc)
                OFS_INDIRECT[6:0]: rbyte = indirect_data; // RL3
                OFS_PC_LOW[6:0]:   rbyte = pc_low;
                OFS_FLAGS[6:0]:    rbyte = flags;
                OFS_POINTER[6:0]:  rbyte = pointer;
                OFS_PC_UPPER[6:0]: rbyte = {3'h0, pc_upper};
                OFS_CORE_IRQ[6:0]: rbyte = core_irq;
                default: begin
                    if (bank == 2'h0) begin
                        unique case (loc)
                            OFS_CCP1_HIGH[6:0]:  rbyte = ccp1_high; // RL7
                            OFS_CCP1_CTRL[6:0]:  rbyte = ccp1_ctrl;
                            OFS_RX_STATUS[6:0]:  rbyte = rx_ctrl | {5'h00, rx_err};
                            OFS_TX_DATA[6:0]:    rbyte = tx_data;
                            OFS_RX_DATA[6:0]:    rbyte = rx_data;
                            OFS_CCP2_LOW[6:0]:   rbyte = ccp2_low;
                            OFS_CCP2_HIGH[6:0]:  rbyte = ccp2_high;
                            OFS_CCP2_CTRL[6:0]:  rbyte = ccp2_ctrl;
                            OFS_CONV_HIGH[6:0]:  rbyte = conv_high;
                            OFS_CONV_CTRL0[6:0]: rbyte = conv_ctrl0;
                            default:             rbyte = 8'h00; // RL1
                        endcase
                    end else if (bank == 2'h1) begin
                        unique case (loc)
                            OFS_OPTIONS[6:0]:    rbyte = options;
                            OFS_DIR_A[6:0]:      rbyte = dir_a & (small_package ?
                                                    MSK_DIR_A_28 : MSK_DIR_A_40); // RL4
                            OFS_DIR_B[6:0]:      rbyte = dir_b;
                            OFS_DIR_C[6:0]:      rbyte = dir_c;
                            OFS_DIR_D[6:0]:      rbyte = small_package ? 8'h00 : dir_d; // RL4
                            OFS_DIR_E[6:0]:      rbyte = small_package ? 8'h00 :
                                                    (dir_e & MSK_DIR_E);            // RL4
                            OFS_PERIPH_IE1[6:0]: rbyte = periph_ie1 & (small_package ?
                                                    MSK_IE1_28 : MSK_IE1_40);     // RL4 RL5
                            OFS_PERIPH_IE2[6:0]: rbyte = periph_ie2;
                            OFS_RESET_WHY[6:0]:  rbyte = reset_why;
                            default:             rbyte = 8'h00; // RL1
                        endcase
                    end
                end
            endcase
        end
    end

    // read data held in a flop, updated on the edge that ends the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 8'h00;
        end else if (psel && !penable && !pwrite) begin
            rdata_q <= rbyte;                          // captured in setup
        end
    end
    assign prdata = {24'h000000, rdata_q};
    // rd_en kept for clarity of timing; data already stable in access
    logic unused_rd;
    assign unused_rd = rd_en;

    // ****************************************************************
    // core-facing outputs
    // ****************************************************************
    assign program_counter        = {pc_high, pc_low};
    assign bank_select            = flags[FLAGS_BANK_LSB+1:FLAGS_BANK_LSB];
    assign indirect_pointer       = pointer;
    assign core_interrupt_control = core_irq;
    assign indirect_write         = wr_en && core_hit(loc, OFS_INDIRECT[6:0]); // RL3
    assign indirect_wdata         = wbyte;
    assign tx_data_out            = tx_data;
    assign tx_data_load           = wr_en && hit(offset, OFS_TX_DATA);
endmodule : sfrb_bank

// *** verification/sfrb_bank_monitor.sv ***
/* sfrb_bank_monitor: timing checks on the apb and core ports.
   assumes: bound into sfrb_bank; byte address is 4 x offset. */
`timescale 1ns/10ps
module sfrb_bank_monitor
    import sfrb_pkg::*;
(
    // apb side
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // core side
    input wire logic              pc_load,
    input wire logic [12:0]       program_counter,
    input wire logic [1:0]        bank_select,
    input wire logic              indirect_write,
    input wire logic [7:0]        indirect_wdata,
    input wire logic              tx_data_load
);
    wire       acc = psel && penable;           // access phase
    wire [6:0] loc = paddr[8:2];                // location, bank ignored
    wire       wr  = acc && pwrite && !paddr[11];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // holding write, then a counter load the very next cycle
    sequence hold_wr; wr && loc == 7'h0a; endsequence
    sequence hold_then_load; hold_wr ##1 pc_load; endsequence
    bus_ready_a: assert property (psel |-> pready && !pslverr)
        else $error("apb answer late or errored");
    read_upper_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read lanes not zero");
    hole_read_a: assert property (acc && !pwrite && (paddr[11] || paddr[10:2] == 9'h08f)
        |-> prdata == 32'h0) else $error("unmapped read not zero");
    pc_merge_a: assert property (hold_then_load
        |=> program_counter[12:8] == $past(pwdata[4:0], 2)) else $error("pc upper wrong");
    indirect_pass_a: assert property (wr && loc == 7'h00
        |-> indirect_write && indirect_wdata == pwdata[7:0]) else $error("indirect missed");
    bank_follow_a: assert property (wr && loc == 7'h03
        |=> bank_select == $past(pwdata[6:5])) else $error("bank select stale");
    tx_load_a: assert property (acc && pwrite |-> tx_data_load == (paddr == 12'h064))
        else $error("transmit load wrong");
    reset_state_a: assert property ($rose(presetn)
        |-> bank_select == 2'b00 && program_counter == 13'h0) else $error("reset state");
endmodule : sfrb_bank_monitor
bind sfrb_bank sfrb_bank_monitor sfrb_bank_monitor_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pc_load(pc_load),
    .program_counter(program_counter), .bank_select(bank_select),
    .indirect_write(indirect_write), .indirect_wdata(indirect_wdata),
    .tx_data_load(tx_data_load));

// *** verification/sfrb_bank_tb_top.sv ***
/* sfrb_bank_tb_top: random and corner-case register bench over apb.
   assumes: zero-wait slave; reset causes are one-cycle pulses. */
`timescale 1ns/10ps
module sfrb_bank_tb_top;
    import sfrb_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready;
    logic pc_load = 0, rx_data_load = 0, small_package = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r, seed = 32'h1805;
    logic [7:0] rx_data_in = 0, indirect_data = 8'h5a, pc_low_in = 0;
    logic [3:0] cause = 0; // por, bor, clear, watchdog
    logic [12:0] program_counter;
    int miscompares = 0, checks_done = 0;
    // read/write registers and their live bits
    logic [8:0] ofs [8] = '{OFS_CCP1_CTRL, OFS_TX_DATA, OFS_CCP2_LOW, OFS_DIR_A,
        OFS_DIR_B, OFS_PERIPH_IE2, OFS_OPTIONS, OFS_PC_UPPER};
    logic [7:0] msk [8] = '{8'h3f, 8'hff, 8'hff, 8'h3f, 8'hff, 8'h89, 8'hff, 8'h1f};
    // cold reset values
    logic [8:0] rof [8] = '{OFS_DIR_A, OFS_DIR_B, OFS_DIR_D, OFS_DIR_E,
        OFS_OPTIONS, OFS_FLAGS, OFS_PERIPH_IE1, OFS_CCP1_CTRL};
    logic [7:0] rvl [8] = '{8'h3f, 8'hff, 8'hff, 8'h07, 8'hff, 8'h18, 8'h00, 8'h00};
    sfrb_bank sfrb_bank_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(), .power_on_reset(cause[0]), .brown_out_reset(cause[1]),
        .external_master_clear(cause[2]), .watchdog_reset(cause[3]),
        .small_package(small_package), .rx_data_in(rx_data_in), .rx_data_load(rx_data_load),
        .rx_status_in(3'h0), .slave_port_status(3'h0), .indirect_data(indirect_data),
        .pc_load(pc_load), .pc_low_in(pc_low_in), .program_counter(program_counter),
        .bank_select(), .indirect_pointer(), .core_interrupt_control(),
        .indirect_write(), .indirect_wdata(), .tx_data_out(), .tx_data_load());
    always #10 pclk = ~pclk; // 50 MHz
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // only live bits come back; dead ones read zero
    function automatic logic [31:0] live(input logic [7:0] v, input logic [7:0] m);
        return {24'h0, v & m};
    endfunction : live
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // one apb transfer; an edge first, so nothing is driven twice
    task automatic xfer(input logic [9:0] o, input logic w, input logic [7:0] v);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {o, 2'b00};
        pwdata <= {24'h0, v};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            miscompares++;
            print_verdict();
        end
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [9:0] o, input logic [7:0] v);
        xfer(o, 1'b1, v);
    endtask : wr
    task automatic rdc(input logic [9:0] o, input logic [7:0] e, input logic [7:0] m = 8'hff);
        xfer(o, 1'b0, 8'h00);
        chk(r, live(e, m));
    endtask : rdc
    task automatic pulse(input int k);
        @(posedge pclk);
        cause <= 4'(1 << k);
        @(posedge pclk);
        cause <= 4'h0;
    endtask : pulse
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rof[i]) rdc(rof[i], rvl[i]);
        for (int k = 0; k < 24; k++) begin
            seed = lfsr(seed);
            wr(ofs[k % 8], seed[7:0]);
            rdc(ofs[k % 8], seed[7:0], msk[k % 8]);
        end
        wr(OFS_CYCLES, 8'hff);
        rdc(OFS_CYCLES, 8'h00);
        rdc(10'h200 | OFS_TX_DATA, 8'h00);
        for (int b = 0; b < 4; b++) begin
            wr({2'(b), 7'h0a}, 8'(b + 9));
            rdc({2'(b + 1), 7'h0a}, 8'(b + 9), 8'h1f);
            rdc({2'(b + 3), 7'h00}, indirect_data);
        end
        wr(OFS_FLAGS, 8'he7);
        rdc(10'h003, 8'hff);
        $display("test registers and mirrors done");
        repeat (3) begin
            seed = lfsr(seed);
            wr(OFS_PC_UPPER, seed[7:0]);
            pc_low_in <= seed[15:8];
            pc_load <= 1'b1;
            @(posedge pclk);
            pc_load <= 1'b0;
            @(posedge pclk);
            chk(32'(program_counter), 32'({seed[4:0], seed[15:8]}));
        end
        rx_data_in <= seed[23:16];
        rx_data_load <= 1'b1;
        @(posedge pclk);
        rx_data_load <= 1'b0;
        rdc(OFS_RX_DATA, seed[23:16]);
        $display("test counter and receive done");
        wr(OFS_DIR_B, 8'h00);
        wr(OFS_RESET_WHY, 8'h03);
        pulse(2);
        rdc(OFS_DIR_B, 8'hff);
        rdc(OFS_FLAGS, 8'h1f);
        pulse(3);
        rdc(OFS_RESET_WHY, 8'h03);
        pulse(1);
        rdc(OFS_RESET_WHY, 8'h02);
        pulse(0);
        rdc(OFS_FLAGS, 8'h18);
        small_package <= 1'b1;
        wr(OFS_PERIPH_IE1, 8'h7f);
        rdc(OFS_DIR_D, 8'h00);
        rdc(OFS_DIR_A, 8'h1f);
        rdc(OFS_DIR_E, 8'h00);
        $display("test resets and small package done");
        print_verdict();
    end
endmodule : sfrb_bank_tb_top
